// *** ccpu_capture_compare_pwm_unit.sv ***
module ccpu_capture_compare_pwm_unit (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        unit_pin_i,
    output logic             unit_pin_o,
    output logic             unit_pin_oe_n_o,
    input  wire logic [15:0] timer_one_count_i,
    output logic             timer_one_reset_o,
    output logic             adc_start_o,
    input  wire logic [7:0]  timer_two_count_i,
    input  wire logic        timer_two_inc_i,
    input  wire logic [1:0]  timer_two_prescale_sel_i,
    input  wire logic [1:0]  timer_two_prescale_bits_i,
    input  wire logic [7:0]  period_match_reg_i,
    output logic             timer_two_clear_o,
    output logic             unit_irq_flag_o
);
    import ccpu_pkg::*;

    ccpu_state_type s_q;
    ccpu_state_type s_d;

    logic        apb_access;
    logic        apb_fire;
    logic        addr_ok;
    logic        wr_control;
    logic        wr_value_low;
    logic        wr_value_high;
    logic        wr_status;
    logic        pin_rise;
    logic        pin_fall;
    logic        cap_evt;
    logic        cmp_match;
    logic        cmp_evt;
    logic        pwm_on;
    logic        pwm_boundary;
    logic [1:0]  duty_ext;
    logic [9:0]  duty_buffered;
    logic [9:0]  pwm_pos;
    logic        pwm_hit;
    logic [31:0] rd_value;

    // apb decode; access phase takes two cycles, the second one completes
    always_comb begin
        apb_access    = psel_i & penable_i;
        apb_fire      = apb_access & s_q.pready;
        addr_ok       = (paddr_i == CCPU_OFS_CONTROL) | (paddr_i == CCPU_OFS_VALUE_LOW) |
                        (paddr_i == CCPU_OFS_VALUE_HIGH) | (paddr_i == CCPU_OFS_STATUS);
        wr_control    = apb_fire & pwrite_i & (paddr_i == CCPU_OFS_CONTROL);
        wr_value_low  = apb_fire & pwrite_i & (paddr_i == CCPU_OFS_VALUE_LOW);
        wr_value_high = apb_fire & pwrite_i & (paddr_i == CCPU_OFS_VALUE_HIGH);
        wr_status     = apb_fire & pwrite_i & (paddr_i == CCPU_OFS_STATUS);
        case (paddr_i)
            CCPU_OFS_CONTROL:    rd_value = {24'h000000, 2'h0, s_q.duty_low, s_q.mode};
            CCPU_OFS_VALUE_LOW:  rd_value = {24'h000000, s_q.value_low};
            CCPU_OFS_VALUE_HIGH: rd_value = {24'h000000, s_q.value_high};
            CCPU_OFS_STATUS:     rd_value = {29'h00000000, s_q.out_latch, s_q.irq_enable, s_q.irq_flag};
            default:             rd_value = 32'h00000000;
        endcase
    end

    // capture edge selection through the edge prescaler
    always_comb begin
        pin_rise = unit_pin_i & ~s_q.pin_prev;
        pin_fall = ~unit_pin_i & s_q.pin_prev;
        case (s_q.mode)
            CCPU_MODE_CAP_FALL:  cap_evt = pin_fall;
            CCPU_MODE_CAP_RISE:  cap_evt = pin_rise;
            CCPU_MODE_CAP_DIV4:  cap_evt = pin_rise & (s_q.presc == CCPU_DIV4_LAST);
            CCPU_MODE_CAP_DIV16: cap_evt = pin_rise & (s_q.presc == CCPU_DIV16_LAST);
            default:             cap_evt = 1'b0;
        endcase
    end

    // compare match acts once, on entry into equality
    always_comb begin
        cmp_match = {s_q.value_high, s_q.value_low} == timer_one_count_i;
        cmp_evt   = ccpu_is_compare(s_q.mode) & cmp_match & ~s_q.match_prev;
    end

    // pwm time base: timer two extended by phase or prescaler bits
    always_comb begin
        pwm_on        = ccpu_is_pwm(s_q.mode);
        duty_ext      = (timer_two_prescale_sel_i == CCPU_T2_PRESCALE_ONE) ?
                        s_q.phase : timer_two_prescale_bits_i;
        duty_buffered = {s_q.value_high, s_q.duty_latch};
        pwm_boundary  = pwm_on & timer_two_inc_i &
                        (timer_two_count_i == period_match_reg_i);
        // latch is registered: at 1:1 look one position ahead so the pin falls as the count reaches the duty
        pwm_pos       = {timer_two_count_i, duty_ext};
        pwm_hit       = (timer_two_prescale_sel_i == CCPU_T2_PRESCALE_ONE) ?
                        (10'(pwm_pos + 10'h001) == duty_buffered) : (pwm_pos == duty_buffered);
    end

    // next-state logic for the whole unit
    always_comb begin
        s_d            = s_q;
        s_d.pin_prev   = unit_pin_i;
        s_d.match_prev = cmp_match;
        s_d.t1_reset   = 1'b0;
        s_d.adc_start  = 1'b0;
        s_d.t2_clear   = 1'b0;

        // bus answer: first access cycle loads data, second completes
        if (apb_fire) begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end else if (apb_access) begin
            s_d.pready  = 1'b1;
            s_d.prdata  = pwrite_i ? 32'h00000000 : rd_value;
            s_d.pslverr = ~addr_ok;
        end

        // software writes
        if (wr_control) begin
            s_d.mode     = pwdata_i[CCPU_MODE_MSB:CCPU_MODE_LSB];
            s_d.duty_low = pwdata_i[CCPU_DUTY_MSB:CCPU_DUTY_LSB];
        end
        if (wr_value_low) begin
            s_d.value_low = pwdata_i[7:0];
        end
        if (wr_value_high & ~pwm_on) begin
            s_d.value_high = pwdata_i[7:0];
        end
        if (wr_status) begin
            s_d.irq_enable = pwdata_i[CCPU_ENABLE_BIT];
            if (pwdata_i[CCPU_FLAG_BIT]) begin
                s_d.irq_flag = 1'b0;
            end
        end

        // capture: prescaler counts rising edges, survives prescaler switches
        if (ccpu_is_capture(s_q.mode)) begin
            if ((s_q.mode == CCPU_MODE_CAP_DIV4) | (s_q.mode == CCPU_MODE_CAP_DIV16)) begin
                if (cap_evt) begin
                    s_d.presc = 4'h0;
                end else if (pin_rise) begin
                    s_d.presc = 4'(s_q.presc + 4'h1);
                end
            end
            if (cap_evt) begin
                s_d.value_low  = timer_one_count_i[7:0];
                s_d.value_high = timer_one_count_i[15:8];
            end
        end else begin
            s_d.presc = 4'h0;
        end

        // compare actions on a fresh match
        if (cmp_evt) begin
            case (s_q.mode)
                CCPU_MODE_CMP_SET: s_d.out_latch = 1'b1;
                CCPU_MODE_CMP_CLR: s_d.out_latch = 1'b0;
                CCPU_MODE_CMP_SPECIAL: begin
                    s_d.t1_reset  = 1'b1;
                    s_d.adc_start = 1'b1;
                end
                default: s_d.out_latch = s_q.out_latch;
            endcase
        end

        // pwm: period end reloads the duty, duty match clears the pin
        if (pwm_on) begin
            s_d.phase = timer_two_inc_i ? 2'h0 : 2'(s_q.phase + 2'h1);
            if (pwm_boundary) begin
                s_d.t2_clear   = 1'b1;
                s_d.value_high = s_q.value_low;
                s_d.duty_latch = s_q.duty_low;
                s_d.out_latch  = {s_q.value_low, s_q.duty_low} != 10'h000;
            end else if (pwm_hit) begin
                s_d.out_latch = 1'b0;
            end
        end else begin
            s_d.phase = 2'h0;
        end

        // mode off resets the unit's latches
        if (s_q.mode == CCPU_MODE_OFF) begin
            s_d.duty_latch = 2'h0;
            s_d.out_latch  = 1'b0;
        end
        if (wr_control & (pwdata_i[7:0] == 8'h00)) begin
            s_d.out_latch = 1'b0;
        end

        // flag: hardware set wins over software clear
        if (cap_evt | cmp_evt) begin
            s_d.irq_flag = 1'b1;
        end

        // pin ownership follows the mode being entered
        s_d.pin_oe_n = ~(ccpu_is_compare(s_d.mode) | ccpu_is_pwm(s_d.mode));
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= CCPU_STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign pready_o          = s_q.pready;
    assign prdata_o          = s_q.prdata;
    assign pslverr_o         = s_q.pslverr;
    assign unit_pin_o        = s_q.out_latch;
    assign unit_pin_oe_n_o   = s_q.pin_oe_n;
    assign timer_one_reset_o = s_q.t1_reset;
    assign adc_start_o       = s_q.adc_start;
    assign timer_two_clear_o = s_q.t2_clear;
    assign unit_irq_flag_o   = s_q.irq_flag;

    // checks on the unit's own behaviour
    // capture copies the timer and raises the flag
    property p_capture_copies;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cap_evt |=> ({s_q.value_high, s_q.value_low} == $past(timer_one_count_i)) && s_q.irq_flag;
    endproperty
    a_capture_copies: assert property (p_capture_copies)
        else $error("capture did not copy timer one or set flag");

    // prescaler idles at zero outside capture
    property p_presc_cleared;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !ccpu_is_capture(s_q.mode) |=> s_q.presc == 4'h0;
    endproperty
    a_presc_cleared: assert property (p_presc_cleared)
        else $error("prescaler not cleared outside capture");

    // divide-by-4 to divide-by-16 switch keeps the count
    property p_presc_kept;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (s_q.mode == CCPU_MODE_CAP_DIV4) && !pin_rise ##1 (s_q.mode == CCPU_MODE_CAP_DIV16)
        |-> s_q.presc == $past(s_q.presc);
    endproperty
    a_presc_kept: assert property (p_presc_kept)
        else $error("prescaler count lost on prescaler switch");

    // compare set drives the pin high
    property p_cmp_set;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cmp_evt && (s_q.mode == CCPU_MODE_CMP_SET) && !wr_control |=> unit_pin_o && unit_irq_flag_o;
    endproperty
    a_cmp_set: assert property (p_cmp_set)
        else $error("compare set did not drive pin high with flag");

    // compare clear drives the pin low
    property p_cmp_clr;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cmp_evt && (s_q.mode == CCPU_MODE_CMP_CLR) |=> !unit_pin_o && unit_irq_flag_o;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr)
        else $error("compare clear did not drive pin low with flag");

    // software-interrupt compare leaves the pin alone
    property p_swi_pin;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cmp_evt && (s_q.mode == CCPU_MODE_CMP_SWI) && !wr_control |=> $stable(unit_pin_o) && unit_irq_flag_o;
    endproperty
    a_swi_pin: assert property (p_swi_pin)
        else $error("software interrupt compare moved the pin");

    // special event gives one reset and conversion pulse
    property p_special;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cmp_evt && (s_q.mode == CCPU_MODE_CMP_SPECIAL) |=> timer_one_reset_o && adc_start_o ##1 !timer_one_reset_o;
    endproperty
    a_special: assert property (p_special)
        else $error("special event trigger pulse wrong");

    // zero control write drops the output latch and the pin driver
    property p_zero_control;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_control && (pwdata_i[7:0] == 8'h00) |=> !unit_pin_o ##1 unit_pin_oe_n_o;
    endproperty
    a_zero_control: assert property (p_zero_control)
        else $error("zero control write left output latch high");

    // period end reloads the duty and sets the pin unless the new duty is zero
    property p_boundary;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        pwm_boundary |=> timer_two_clear_o && (duty_buffered == $past({s_q.value_low, s_q.duty_low}))
                         && (unit_pin_o == ($past({s_q.value_low, s_q.duty_low}) != 10'h000));
    endproperty
    a_boundary: assert property (p_boundary)
        else $error("period boundary did not reload duty");

    // high byte ignores software in pwm
    property p_high_readonly;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_value_high && pwm_on && !pwm_boundary |=> $stable(s_q.value_high);
    endproperty
    a_high_readonly: assert property (p_high_readonly)
        else $error("value high byte written in pwm mode");

    // pin left to the port outside compare and pwm
    property p_pin_owner;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        ccpu_is_capture(s_q.mode) || (s_q.mode == CCPU_MODE_OFF) |-> unit_pin_oe_n_o;
    endproperty
    a_pin_owner: assert property (p_pin_owner)
        else $error("pin driven outside compare or pwm");

    // bus answers after exactly one wait state
    property p_apb_answer;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not given after one wait cycle");

    // a software clear sticks when no event sets the flag in the same cycle
    property p_flag_clear;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_status && pwdata_i[CCPU_FLAG_BIT] && !cap_evt && !cmp_evt |=> !unit_irq_flag_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("status write did not clear the unit flag");

    // mode off holds the output and duty latches low
    property p_mode_off;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_q.mode == CCPU_MODE_OFF |=> !unit_pin_o && (s_q.duty_latch == 2'h0);
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("mode off left a latch set");

    // the duty position match clears the pin
    property p_pwm_clear;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        pwm_on && pwm_hit && !pwm_boundary |=> !unit_pin_o;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear)
        else $error("duty match did not clear the pin");

    // a duty beyond the period keeps the pin high
    property p_pwm_full;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        pwm_on && unit_pin_o && !wr_control && !pwm_boundary && (duty_buffered > {period_match_reg_i, 2'h3})
        |=> unit_pin_o;
    endproperty
    a_pwm_full: assert property (p_pwm_full)
        else $error("pin cleared with duty beyond the period");

    // buffered duty only moves at a period boundary
    property p_duty_hold;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        pwm_on && !pwm_boundary |=> $stable(duty_buffered);
    endproperty
    a_duty_hold: assert property (p_duty_hold)
        else $error("buffered duty changed inside a period");

    c_capture: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cap_evt && (s_q.mode == CCPU_MODE_CAP_DIV16));
    c_special: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cmp_evt && (s_q.mode == CCPU_MODE_CMP_SPECIAL));
    c_pwm_cycle: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pwm_boundary ##[1:1000] (pwm_on && !unit_pin_o));
    c_apb_error: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pready_o && pslverr_o);

endmodule : ccpu_capture_compare_pwm_unit

// *** ccpu_capture_compare_pwm_unit_bench.sv ***
module ccpu_capture_compare_pwm_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ccpu_pkg::*;

    typedef struct packed { logic [3:0] mode; logic pin; } ccpu_cmp_row_type;
    typedef struct packed { logic [9:0] duty; logic [7:0] high; } ccpu_pwm_row_type;

    // compare rows: mode and the pin level after the match
    localparam ccpu_cmp_row_type CMP_ROWS [4] = '{'{4'h8, 1'b1}, '{4'hA, 1'b1}, '{4'h9, 1'b0}, '{4'hB, 1'b0}};
    // pwm rows: 10-bit duty and high clocks over four 16-clock periods
    localparam ccpu_pwm_row_type PWM_ROWS [3] = '{'{10'h000, 8'h00}, '{10'h006, 8'h18}, '{10'h3FC, 8'h40}};

    logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic        pin_o, oe_n, t1_rst, adc, t2_clr, irq, ext, pin, t2_run;
    logic [7:0]  paddr, t2;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] t1;
    logic [1:0]  ph;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          hi, nt;

    ccpu_capture_compare_pwm_unit i_ccpu_capture_compare_pwm_unit (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .unit_pin_i(pin), .unit_pin_o(pin_o),
        .unit_pin_oe_n_o(oe_n), .timer_one_count_i(t1), .timer_one_reset_o(t1_rst),
        .adc_start_o(adc), .timer_two_count_i(t2), .timer_two_inc_i(t2_run && ph == 2'h3),
        .timer_two_prescale_sel_i(CCPU_T2_PRESCALE_ONE), .timer_two_prescale_bits_i(2'h0),
        .period_match_reg_i(8'h03), .timer_two_clear_o(t2_clr), .unit_irq_flag_o(irq));

    ccpu_pin_partner i_ccpu_pin_partner (.ext_level_i(ext), .unit_level_i(pin_o), .unit_oe_n_i(oe_n), .pin_o(pin));

    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // timer two with 1:1 prescale, period register 3, one step every four clocks
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
        if (t2_run) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) t2 <= (t2 == 8'h03) ? 8'h00 : t2 + 8'h01;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hung transfer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    task automatic edge_pulse();
        ext <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ext <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : edge_pulse

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        {reset_n, psel, penable, pwrite, ext, t2_run} = '0;
        {paddr, t2, ph, pwdata, t1} = '0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        chk(oe_n, 1'b1);
        rd(CCPU_OFS_CONTROL, 32'h0);
        rd(CCPU_OFS_STATUS, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rdat, 32'h0);
        apb(1'b1, CCPU_OFS_VALUE_LOW, 32'h34);
        apb(1'b1, CCPU_OFS_VALUE_HIGH, 32'h12);
        foreach (CMP_ROWS[i]) begin
            t1 <= 16'h0000;
            apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CMP_ROWS[i].mode});
            nt = 0;
            t1 <= 16'h1234;
            repeat (4) begin
                @(posedge ref_clk);
                if (t1_rst === 1'b1) nt++;
                if (t1_rst === 1'b1) chk(adc, 1'b1);
            end
            chk(nt, CMP_ROWS[i].mode == CCPU_MODE_CMP_SPECIAL);
            chk({oe_n, pin}, {1'b0, CMP_ROWS[i].pin});
            chk(irq, 1'b1);
            rd(CCPU_OFS_STATUS, {29'h0, CMP_ROWS[i].pin, 2'b01});
            apb(1'b1, CCPU_OFS_STATUS, 32'h1);
        end
        t1 <= 16'h0000;
        apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CCPU_MODE_CMP_SET});
        t1 <= 16'h1234;
        repeat (4) @(posedge ref_clk);
        chk(pin_o, 1'b1);
        apb(1'b1, CCPU_OFS_CONTROL, 32'h0);
        @(posedge ref_clk);
        chk({oe_n, pin_o}, 2'b10);
        // capture on a rising then a falling edge
        apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CCPU_MODE_CAP_RISE});
        apb(1'b1, CCPU_OFS_STATUS, 32'h1);
        t1 <= 16'h0ABC;
        ext <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b1);
        rd(CCPU_OFS_VALUE_LOW, 32'hBC);
        rd(CCPU_OFS_VALUE_HIGH, 32'h0A);
        apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CCPU_MODE_CAP_FALL});
        apb(1'b1, CCPU_OFS_STATUS, 32'h1);
        t1 <= 16'h0BCD;
        ext <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(CCPU_OFS_VALUE_LOW, 32'hCD);
        // every fourth rising edge: three edges give nothing
        apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CCPU_MODE_CAP_DIV4});
        apb(1'b1, CCPU_OFS_STATUS, 32'h1);
        t1 <= 16'h0155;
        repeat (3) edge_pulse();
        rd(CCPU_OFS_STATUS, 32'h0);
        edge_pulse();
        rd(CCPU_OFS_STATUS, 32'h1);
        rd(CCPU_OFS_VALUE_LOW, 32'h55);
        // two edges counted, then a switch to every sixteenth keeps the count
        repeat (2) edge_pulse();
        apb(1'b1, CCPU_OFS_CONTROL, {28'h0, CCPU_MODE_CAP_DIV16});
        apb(1'b1, CCPU_OFS_STATUS, 32'h1);
        t1 <= 16'h0166;
        repeat (13) edge_pulse();
        rd(CCPU_OFS_STATUS, 32'h0);
        edge_pulse();
        rd(CCPU_OFS_STATUS, 32'h1);
        rd(CCPU_OFS_VALUE_LOW, 32'h66);
        // pwm rows: zero, mid and beyond-period duty
        apb(1'b1, CCPU_OFS_CONTROL, 32'h0);
        t2_run <= 1'b1;
        foreach (PWM_ROWS[i]) begin
            apb(1'b1, CCPU_OFS_VALUE_LOW, {24'h0, PWM_ROWS[i].duty[9:2]});
            apb(1'b1, CCPU_OFS_CONTROL, {26'h0, PWM_ROWS[i].duty[1:0], 4'hC});
            repeat (40) @(posedge ref_clk);
            hi = 0;
            nt = 0;
            repeat (64) begin
                @(posedge ref_clk);
                hi += (pin === 1'b1);
                nt += (t2_clr === 1'b1);
            end
            chk(hi, PWM_ROWS[i].high);
            chk(nt, 4);
            rd(CCPU_OFS_VALUE_HIGH, {24'h0, PWM_ROWS[i].duty[9:2]});
            apb(1'b1, CCPU_OFS_VALUE_HIGH, 32'h5A);
            rd(CCPU_OFS_VALUE_HIGH, {24'h0, PWM_ROWS[i].duty[9:2]});
        end
        chk(pin_o, 1'b1);
        apb(1'b1, CCPU_OFS_CONTROL, 32'h0);
        @(posedge ref_clk);
        chk({oe_n, pin_o}, 2'b10);
        // enable bit is plain storage; a mid-run reset clears it with the rest
        apb(1'b1, CCPU_OFS_STATUS, 32'h3);
        rd(CCPU_OFS_STATUS, 32'h2);
        apb(1'b1, CCPU_OFS_CONTROL, 32'h0C);
        repeat (40) @(posedge ref_clk);
        chk({oe_n, pin_o}, 2'b01);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        chk({oe_n, pin_o, irq}, 3'b100);
        reset_n <= 1'b1;
        rd(CCPU_OFS_STATUS, 32'h0);
        rd(CCPU_OFS_CONTROL, 32'h0);
        tally_and_finish();
    end
endmodule : ccpu_capture_compare_pwm_unit_bench

// *** ccpu_pin_partner.sv ***
module ccpu_pin_partner (
    input  wire logic ext_level_i,
    input  wire logic unit_level_i,
    input  wire logic unit_oe_n_i,
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // outside circuit drives the wire only while the unit has its driver off
    assign pin_o = unit_oe_n_i ? ext_level_i : unit_level_i;
endmodule : ccpu_pin_partner

// *** ccpu_pkg.sv ***
// Functional notes
// - decode 4-bit mode: zero disables and resets, codes pick capture/compare, 11xx is pwm
// - capture copies timer-one count into value pair, sets flag, overwrites unread value
// - capture mode changes may set the flag; software masks enable and clears flag
// - capture prescaler counter cleared whenever unit is off or not capturing
// - switching between capture prescalers keeps the prescaler count
// - compare mode matches value pair with timer one; drive high, low or hold
// - every compare match sets the unit flag with the pin action
// - writing zero to control forces the compare output latch low
// - software-interrupt compare only sets the flag, pin level untouched
// - special event match resets timer one and starts a conversion
// - special event reset does not raise the timer-one overflow flag
// - pwm mode makes a waveform with up to 10-bit duty resolution
// - pwm period is (period+1) times 4 oscillator periods times timer-two prescale
// - at period end: clear timer two, set pin unless duty zero, load duty
// - timer-two postscaler plays no part in pwm period
// - duty is value low byte over control bits 5:4
// - duty writes take effect at period end; high byte read-only in pwm
// - duty double-buffered in value high byte plus 2-bit latch
// - pin cleared when buffered duty equals timer two plus phase or prescale bits
// - duty beyond period never clears the pin, giving full duty
// - writing zero to control forces the pwm output latch low
package ccpu_pkg;

    // register byte offsets
    localparam logic [7:0] CCPU_OFS_CONTROL    = 8'h00;
    localparam logic [7:0] CCPU_OFS_VALUE_LOW  = 8'h04;
    localparam logic [7:0] CCPU_OFS_VALUE_HIGH = 8'h08;
    localparam logic [7:0] CCPU_OFS_STATUS     = 8'h0C;

    // field positions
    localparam int CCPU_MODE_LSB   = 0;
    localparam int CCPU_MODE_MSB   = 3;
    localparam int CCPU_DUTY_LSB   = 4;
    localparam int CCPU_DUTY_MSB   = 5;
    localparam int CCPU_FLAG_BIT   = 0;
    localparam int CCPU_ENABLE_BIT = 1;
    localparam int CCPU_PIN_BIT    = 2;

    // mode codes
    localparam logic [3:0] CCPU_MODE_OFF      = 4'h0;
    localparam logic [3:0] CCPU_MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] CCPU_MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] CCPU_MODE_CAP_DIV4 = 4'h6;
    localparam logic [3:0] CCPU_MODE_CAP_DIV16 = 4'h7;
    localparam logic [3:0] CCPU_MODE_CMP_SET  = 4'h8;
    localparam logic [3:0] CCPU_MODE_CMP_CLR  = 4'h9;
    localparam logic [3:0] CCPU_MODE_CMP_SWI  = 4'hA;
    localparam logic [3:0] CCPU_MODE_CMP_SPECIAL = 4'hB;
    localparam logic [1:0] CCPU_CLASS_CAPTURE = 2'h1;
    localparam logic [1:0] CCPU_CLASS_COMPARE = 2'h2;
    localparam logic [1:0] CCPU_CLASS_PWM     = 2'h3;

    // prescaler terminal counts and timer-two prescale select for 1:1
    localparam logic [3:0] CCPU_DIV4_LAST      = 4'h3;
    localparam logic [3:0] CCPU_DIV16_LAST     = 4'hF;
    localparam logic [1:0] CCPU_T2_PRESCALE_ONE = 2'h0;
    localparam logic [1:0] CCPU_PHASE_LAST     = 2'h3;  // four oscillator periods per timer-two step

    typedef struct packed {
        logic [3:0]  mode;
        logic [1:0]  duty_low;
        logic [7:0]  value_low;
        logic [7:0]  value_high;
        logic        irq_flag;
        logic        irq_enable;
        logic [1:0]  duty_latch;
        logic [3:0]  presc;
        logic        pin_prev;
        logic        match_prev;
        logic        out_latch;
        logic        pin_oe_n;
        logic [1:0]  phase;
        logic        t1_reset;
        logic        adc_start;
        logic        t2_clear;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ccpu_state_type;

    localparam ccpu_state_type CCPU_STATE_RESET = '{pin_oe_n: 1'b1, default: '0};

    // mode class decode
    function automatic logic ccpu_is_capture(input logic [3:0] mode);
        return mode[3:2] == CCPU_CLASS_CAPTURE;
    endfunction : ccpu_is_capture

    function automatic logic ccpu_is_compare(input logic [3:0] mode);
        return mode[3:2] == CCPU_CLASS_COMPARE;
    endfunction : ccpu_is_compare

    function automatic logic ccpu_is_pwm(input logic [3:0] mode);
        return mode[3:2] == CCPU_CLASS_PWM;
    endfunction : ccpu_is_pwm

endpackage : ccpu_pkg
